// ==== shared/fws_pkg.sv ====
package fws_pkg;
    // ==========================================================
    // Flash status bit positions
    localparam int POLL_BIT_POS = 7;
    localparam int GTOG_BIT_POS = 6;
    localparam int FAIL_BIT_POS = 5;
    localparam int STOG_BIT_POS = 2;
    // ==========================================================
    // Flash commands
    localparam logic [7:0] CMD_RESET = 8'hf0;
    // ==========================================================
    // Bus timing in ref_clk cycles (10 MHz, 100 ns period)
    localparam int CLK_PERIOD_NS = 100;
    localparam int STROBE_LOW_NS = 200;
    localparam int STROBE_LOW_CYC = (STROBE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RECOVER_NS = 100;
    localparam int RECOVER_CYC = (RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // ==========================================================
    // Controller register map (byte offsets)
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_ADDR = 4'h4;
    localparam logic [3:0] REG_DATA = 4'h8;
    localparam logic [3:0] REG_STAT = 4'hc;
    // CTRL fields
    localparam int CTRL_GO_POS = 0;
    localparam int CTRL_MODE_POS = 1;
    localparam int CTRL_RESET_POS = 2;
    localparam int CTRL_POLL_POS = 3;
    // STAT fields
    localparam int STAT_BUSY_POS = 0;
    localparam int STAT_DONE_POS = 1;
    localparam int STAT_FAIL_POS = 2;
    localparam int STAT_SUSP_POS = 3;
    localparam logic [16:0] ADDR_RESET = 17'h00000;
    localparam logic [7:0] DATA_RESET = 8'h00;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    // Sequencer states
    typedef enum logic [6:0] {
        ST_IDLE = 7'b0000001,
        ST_WRITE = 7'b0000010,
        ST_READ = 7'b0000100,
        ST_GAP = 7'b0001000,
        ST_EVAL = 7'b0010000,
        ST_FAILRST = 7'b0100000,
        ST_FINAL = 7'b1000000
    } fws_state_type;
endpackage

// ==== core/fws_bus_cycle.sv ====
`timescale 1ns/1ps
`default_nettype none
module fws_bus_cycle
    import fws_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Request
    input wire logic start,
    input wire logic isWrite,
    input wire logic [16:0] cycAddr,
    input wire logic [7:0] cycWdata,
    output logic cycDone,
    output logic [7:0] cycRdata,
    // Flash pins
    output logic [16:0] flashAddr,
    output logic [7:0] flashDqOut,
    output logic flashDqOe,
    input wire logic [7:0] flashDqIn,
    output logic chipSel_n,
    output logic outStrobe_n,
    output logic writeStrobe_n
);
    import fws_pkg::*;
    // ==========================================================
    // One strobe-framed cycle; data captured after two flops
    logic [7:0] dqMeta_reg;
    logic [7:0] dqSync_reg;
    logic [3:0] cnt_reg;
    logic active_reg;
    logic wr_reg;
    // Strobe width counts synchronizer delay as well
    localparam logic [3:0] LOW_CNT = 4'(STROBE_LOW_CYC + 2);
    localparam logic [3:0] REC_CNT = 4'(RECOVER_CYC);
    always_ff @(posedge ref_clk) begin
        dqMeta_reg <= flashDqIn;
        dqSync_reg <= dqMeta_reg;
    end
    // Cycle sequencing: low phase then recovery high phase
    always_ff @(posedge ref_clk) begin
        cycDone <= 1'b0;
        if (rst) begin
            active_reg <= 1'b0;
            wr_reg <= 1'b0;
            cnt_reg <= 4'h0;
            cycRdata <= 8'h00;
            flashAddr <= 17'h00000;
            flashDqOut <= 8'h00;
            flashDqOe <= 1'b0;
            chipSel_n <= 1'b1;
            outStrobe_n <= 1'b1;
            writeStrobe_n <= 1'b1;
        end else if (!active_reg && start) begin
            active_reg <= 1'b1;
            wr_reg <= isWrite;
            cnt_reg <= LOW_CNT;
            flashAddr <= cycAddr;
            flashDqOut <= cycWdata;
            flashDqOe <= isWrite;
            chipSel_n <= 1'b0;
            outStrobe_n <= isWrite;
            writeStrobe_n <= !isWrite;
        end else if (active_reg && cnt_reg != 4'h0) begin
            cnt_reg <= cnt_reg - 4'h1;
        end else if (active_reg && !chipSel_n) begin
            // Raising CS also ends the read, so every read is a fresh toggle sample
            chipSel_n <= 1'b1;
            outStrobe_n <= 1'b1;
            writeStrobe_n <= 1'b1;
            if (!wr_reg) begin
                cycRdata <= dqSync_reg;
            end
            cnt_reg <= REC_CNT;
        end else if (active_reg) begin
            flashDqOe <= 1'b0;
            active_reg <= 1'b0;
            cycDone <= 1'b1;
        end
    end
endmodule
`default_nettype wire

// ==== core/fws_status_poller.sv ====
`timescale 1ns/1ps
`default_nettype none
module fws_status_poller
    import fws_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // AXI4-Lite write address and data
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Flash pins
    output logic [16:0] flashAddr,
    output logic [7:0] flashDqOut,
    output logic flashDqOe,
    input wire logic [7:0] flashDqIn,
    output logic chipSel_n,
    output logic outStrobe_n,
    output logic writeStrobe_n
);
    import fws_pkg::*;
    // ==========================================================
    // Registers
    fws_state_type state_reg;
    logic [16:0] addr_reg;
    logic [7:0] data_reg;
    logic mode_reg;
    logic busy_reg, done_reg, fail_reg, susp_reg;
    logic [7:0] first_reg;
    logic [7:0] last_reg;
    logic haveFirst_reg;
    logic failSeen_reg;
    logic [1:0] kind_reg;
    logic awHeld_reg, wHeld_reg;
    logic [3:0] awAddr_reg;
    logic [31:0] wData_reg;
    logic [3:0] wStrb_reg;
    logic cycStart_reg, cycWrite_reg;
    logic [7:0] cycWdata_reg;
    logic cycDone;
    logic [7:0] cycRdata;
    // ==========================================================
    // Bus cycle engine
    fws_bus_cycle uCycle (
        .ref_clk(ref_clk),
        .rst(rst),
        .start(cycStart_reg),
        .isWrite(cycWrite_reg),
        .cycAddr(addr_reg),
        .cycWdata(cycWdata_reg),
        .cycDone(cycDone),
        .cycRdata(cycRdata),
        .flashAddr(flashAddr),
        .flashDqOut(flashDqOut),
        .flashDqOe(flashDqOe),
        .flashDqIn(flashDqIn),
        .chipSel_n(chipSel_n),
        .outStrobe_n(outStrobe_n),
        .writeStrobe_n(writeStrobe_n)
    );
    // ==========================================================
    // Register decode
    wire writeFire = awHeld_reg && wHeld_reg && !s_axi_bvalid;
    wire wrCtrl = writeFire && awAddr_reg == REG_CTRL && wStrb_reg[0];
    wire wrAddr = writeFire && awAddr_reg == REG_ADDR && !busy_reg;
    wire wrData = writeFire && awAddr_reg == REG_DATA && wStrb_reg[0] && !busy_reg;
    wire wrMapped = awAddr_reg == REG_CTRL || awAddr_reg == REG_ADDR ||
                    awAddr_reg == REG_DATA || awAddr_reg == REG_STAT;
    wire goCmd = wrCtrl && wData_reg[CTRL_GO_POS] && !busy_reg;
    wire readFire = s_axi_arvalid && s_axi_arready;
    wire [3:0] statWord = {susp_reg, fail_reg, done_reg, busy_reg};
    wire [31:0] rdWord =
        (s_axi_araddr == REG_CTRL) ? {30'h0, mode_reg, 1'b0} :
        (s_axi_araddr == REG_ADDR) ? {15'h0, addr_reg} :
        (s_axi_araddr == REG_DATA) ? {16'h0, last_reg, data_reg} :
        (s_axi_araddr == REG_STAT) ? {28'h0, statWord} : 32'h0;
    wire rdMapped = s_axi_araddr == REG_CTRL || s_axi_araddr == REG_ADDR ||
                    s_axi_araddr == REG_DATA || s_axi_araddr == REG_STAT;
    // Status evaluation on each completed read
    wire togNow = first_reg[GTOG_BIT_POS] != cycRdata[GTOG_BIT_POS];
    wire stogNow = last_reg[STOG_BIT_POS] != cycRdata[STOG_BIT_POS];
    wire failBit = cycRdata[FAIL_BIT_POS];
    // Polling mode: bit 7 matches expected true data
    wire pollTrue = cycRdata[POLL_BIT_POS] == data_reg[POLL_BIT_POS];
    // ==========================================================
    // AXI write channel capture, either order
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            awHeld_reg <= 1'b0;
            wHeld_reg <= 1'b0;
            awAddr_reg <= 4'h0;
            wData_reg <= 32'h0;
            wStrb_reg <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awHeld_reg <= 1'b1;
                awAddr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHeld_reg <= 1'b1;
                wData_reg <= s_axi_wdata;
                wStrb_reg <= s_axi_wstrb;
            end
            if (writeFire) begin
                awHeld_reg <= 1'b0;
                wHeld_reg <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wrMapped ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end
    // Ready outputs kept as flops, low while a word is held
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
        end else begin
            s_axi_awready <= !awHeld_reg && !(s_axi_awvalid && s_axi_awready) && !writeFire;
            s_axi_wready <= !wHeld_reg && !(s_axi_wvalid && s_axi_wready) && !writeFire;
        end
    end
    // AXI read channel; one-cycle answer
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= RESP_OKAY;
        end else if (readFire) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rdWord;
            s_axi_rresp <= rdMapped ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end else if (!s_axi_rvalid) begin
            s_axi_arready <= 1'b1;
        end
    end
    // ==========================================================
    // Configuration registers
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            addr_reg <= ADDR_RESET;
            data_reg <= DATA_RESET;
            mode_reg <= 1'b0;
        end else begin
            // Address must be the program or an erasing sector address
            if (wrAddr) begin
                addr_reg <= wData_reg[16:0];
            end
            if (wrData) begin
                data_reg <= wData_reg[7:0];
            end
            if (wrCtrl && !busy_reg) begin
                mode_reg <= wData_reg[CTRL_MODE_POS];
            end
        end
    end
    // ==========================================================
    // Polling sequencer; kind 0 toggle, 1 data poll, 2 reset write
    always_ff @(posedge ref_clk) begin
        cycStart_reg <= 1'b0;
        if (rst) begin
            state_reg <= ST_IDLE;
            busy_reg <= 1'b0;
            done_reg <= 1'b0;
            fail_reg <= 1'b0;
            susp_reg <= 1'b0;
            first_reg <= 8'h00;
            last_reg <= 8'h00;
            haveFirst_reg <= 1'b0;
            failSeen_reg <= 1'b0;
            kind_reg <= 2'd0;
            cycWrite_reg <= 1'b0;
            cycWdata_reg <= 8'h00;
        end else begin
            unique case (state_reg)
                ST_IDLE: begin
                    // Started only by software after the final command write
                    if (goCmd) begin
                        busy_reg <= 1'b1;
                        done_reg <= 1'b0;
                        fail_reg <= 1'b0;
                        susp_reg <= 1'b0;
                        failSeen_reg <= 1'b0;
                        // Each toggle start begins with a fresh double read; poll starts read once per check, reset starts write
                        haveFirst_reg <= 1'b0;
                        if (wData_reg[CTRL_RESET_POS]) begin
                            kind_reg <= 2'd2;
                            cycWrite_reg <= 1'b1;
                            cycWdata_reg <= CMD_RESET;
                            state_reg <= ST_WRITE;
                        end else begin
                            kind_reg <= {1'b0, wData_reg[CTRL_POLL_POS]};
                            cycWrite_reg <= 1'b0;
                            state_reg <= ST_READ;
                        end
                        cycStart_reg <= 1'b1;
                    end
                end
                ST_WRITE: begin
                    if (cycDone) begin
                        busy_reg <= 1'b0;
                        done_reg <= kind_reg == 2'd2;
                        state_reg <= ST_IDLE;
                    end
                end
                ST_READ: begin
                    if (cycDone) begin
                        last_reg <= cycRdata;
                        state_reg <= ST_EVAL;
                    end
                end
                ST_EVAL: begin
                    state_reg <= ST_GAP;
                    if (kind_reg == 2'd1) begin
                        // Complement while busy, true when done; fail rechecks bit 7
                        if (pollTrue) begin
                            state_reg <= ST_FINAL;
                            cycStart_reg <= 1'b1;
                        end else if (failSeen_reg) begin
                            state_reg <= ST_FAILRST;
                        end else if (failBit) begin
                            failSeen_reg <= 1'b1;
                        end
                    end else if (!haveFirst_reg) begin
                        // First of the mandatory pair
                        first_reg <= cycRdata;
                        haveFirst_reg <= 1'b1;
                    end else if (!togNow) begin
                        // Stopped toggling: one final read, started once only
                        cycStart_reg <= 1'b1;
                        state_reg <= ST_FINAL;
                    end else if (failSeen_reg) begin
                        // Still toggling after fail was seen
                        state_reg <= ST_FAILRST;
                    end else begin
                        // Busy flips global toggle
                        failSeen_reg <= failBit;
                        first_reg <= cycRdata;
                    end
                end
                ST_GAP: begin
                    cycWrite_reg <= 1'b0;
                    cycStart_reg <= 1'b1;
                    state_reg <= ST_READ;
                end
                ST_FINAL: begin
                    // Extra read gives a settled whole byte
                    if (cycDone) begin
                        last_reg <= cycRdata;
                        // Array reads repeat; a suspended sector still flips bit 2
                        susp_reg <= kind_reg == 2'd0 && stogNow;
                        busy_reg <= 1'b0;
                        done_reg <= 1'b1;
                        state_reg <= ST_IDLE;
                    end
                end
                ST_FAILRST: begin
                    // Failure: write reset command automatically
                    fail_reg <= 1'b1;
                    kind_reg <= 2'd3;
                    cycWrite_reg <= 1'b1;
                    cycWdata_reg <= CMD_RESET;
                    cycStart_reg <= 1'b1;
                    state_reg <= ST_WRITE;
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// ==== verif/fws_flash_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// =============================================================
// Behavioural flash that answers status reads; bench steers it
module fws_flash_model
    import fws_pkg::*;
(
    // Flash pins
    input wire logic [16:0] flashAddr,
    input wire logic [7:0] flashDqOut,
    input wire logic flashDqOe,
    output logic [7:0] flashDqIn,
    input wire logic chipSel_n,
    input wire logic outStrobe_n,
    input wire logic writeStrobe_n
);
    // Op state: 0 array, 1 program, 2 erase, 3 suspended, 4 failed
    logic [2:0] mode = 3'd0;
    int left = 0;
    int resetCount = 0;
    logic [7:0] progData = 8'h00, arrayByte = 8'hff, shown = 8'h00, wrByte = 8'h00;
    logic [16:0] readAddr = 17'h00000;
    logic gTog = 1'b0, sTog = 1'b0, inRead = 1'b0;
    logic pollBit;
    // Program or failure shows complement, erase 0, suspend 1
    assign pollBit = (mode == 3'd2) ? 1'b0 : ((mode == 3'd3) ? 1'b1 : ~progData[7]);
    // Released bus shows the inverse of the last byte, not a held copy
    assign flashDqIn = (!chipSel_n && !outStrobe_n) ? shown : ~shown;
    // Byte fixed at read start; 1 ns lets both strobes settle
    always @(negedge outStrobe_n) begin
        #1;
        if (!chipSel_n && !outStrobe_n) begin
            inRead = 1'b1;
            readAddr = flashAddr;
            shown = (mode == 3'd0) ? arrayByte : {pollBit, gTog, mode == 3'd4, 2'b00, sTog, 2'b00};
        end
    end
    // Each finished read advances the embedded operation
    always @(posedge chipSel_n) begin
        if (inRead) begin
            inRead = 1'b0;
            if (mode != 3'd0 && mode != 3'd3) gTog = ~gTog;
            if (mode == 3'd2 || mode == 3'd3) sTog = ~sTog;
            if (mode == 3'd1 || mode == 3'd2) left = left - 1;
            if ((mode == 3'd1 || mode == 3'd2) && left <= 0) mode = 3'd0;
        end
    end
    // Data latched inside the write pulse, acted on at its rise
    always @(negedge writeStrobe_n) begin
        #1;
        wrByte = flashDqOut;
    end
    always @(posedge writeStrobe_n) begin
        if (wrByte == CMD_RESET) begin
            resetCount = resetCount + 1;
            if (mode == 3'd4) mode = 3'd0;
        end
    end
endmodule
`default_nettype wire

// ==== verif/fws_status_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none
// =============================================================
// Flash pin discipline and register bus answers
module fws_status_checker
    import fws_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Register bus answers
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Flash pins
    input wire logic [16:0] flashAddr,
    input wire logic [7:0] flashDqOut,
    input wire logic flashDqOe,
    input wire logic chipSel_n,
    input wire logic outStrobe_n,
    input wire logic writeStrobe_n
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    a_read_strobe_len: assert property (
        $fell(outStrobe_n) |-> (!outStrobe_n)[*5] ##1 outStrobe_n)
        else $error("read strobe not low for five cycles");
    a_read_in_select: assert property (
        !outStrobe_n |-> !chipSel_n)
        else $error("read strobe without chip select");
    a_read_new_sample: assert property (
        $rose(outStrobe_n) |-> $rose(chipSel_n))
        else $error("read ended without chip select rising");
    a_addr_steady: assert property (
        !chipSel_n && !$past(chipSel_n) |-> $stable(flashAddr))
        else $error("flash address moved inside a cycle");
    a_no_contention: assert property (
        !outStrobe_n |-> !flashDqOe)
        else $error("data driven during a read");
    a_write_is_reset: assert property (
        !writeStrobe_n |-> flashDqOe && flashDqOut == CMD_RESET && !chipSel_n && outStrobe_n)
        else $error("write cycle is not a reset command");
    a_write_strobe_len: assert property (
        $fell(writeStrobe_n) |-> (flashDqOe && !writeStrobe_n)[*2])
        else $error("write pulse too short");
    a_recover_gap: assert property (
        $rose(chipSel_n) |-> chipSel_n[*2])
        else $error("no recovery between flash cycles");
    a_bresp_held: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    a_rdata_held: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
endmodule
bind fws_status_poller fws_status_checker fws_status_checker_i (.*);
`default_nettype wire

// ==== verif/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import fws_pkg::*;
    typedef struct {logic [31:0] val; logic [31:0] mask;} fws_note_type;
    logic ref_clk = 1'b0, rst = 1'b1;
    logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [16:0] flashAddr;
    logic [7:0] flashDqOut, flashDqIn, pd;
    logic flashDqOe, chipSel_n, outStrobe_n, writeStrobe_n;
    fws_note_type rdQ[$];
    fws_note_type note;
    int bad_count = 0, checked = 0, rc = 0, i, seedDummy;
    always #50 ref_clk = ~ref_clk;
    fws_status_poller fws_status_poller_i (.*);
    fws_flash_model fws_flash_model_i (.*);
    // =============================================================
    // Compare helpers and closing
    task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk_resp(input string what, input logic [1:0] exp, input logic [1:0] got);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // Watcher: every read answer is matched with the oldest note
    always @(posedge ref_clk) begin
        if (s_axi_rvalid && s_axi_rready) begin
            note = rdQ.pop_front();
            chk_resp("read response", RESP_OKAY, s_axi_rresp);
            if (note.mask != 32'h0) chk_word("read data", note.val & note.mask, s_axi_rdata & note.mask);
        end
        if (s_axi_bvalid && s_axi_bready) chk_resp("write response", RESP_OKAY, s_axi_bresp);
    end
    // =============================================================
    // Register bus master; both channels offered together
    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
        logic awDone, wDone;
        awDone = 1'b0;
        wDone = 1'b0;
        @(posedge ref_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hf;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(awDone && wDone)) begin
            @(posedge ref_clk);
            if (!awDone && s_axi_awready) begin
                s_axi_awvalid <= 1'b0;
                awDone = 1'b1;
            end
            if (!wDone && s_axi_wready) begin
                s_axi_wvalid <= 1'b0;
                wDone = 1'b1;
            end
        end
        while (!s_axi_bvalid) @(posedge ref_clk);
        s_axi_bready <= 1'b0;
    endtask
    task automatic axi_rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e,
                          output logic [31:0] d);
        rdQ.push_back('{e, m});
        @(posedge ref_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge ref_clk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        while (!s_axi_rvalid) @(posedge ref_clk);
        d = s_axi_rdata;
        s_axi_rready <= 1'b0;
    endtask
    // One polling run: program the flash state, start, wait, check
    task automatic run_op(input logic [2:0] m, input int lft, input logic [7:0] dat,
                          input logic [31:0] ctrl, input logic [3:0] st, input logic [3:0] stMask,
                          input logic [7:0] last, input logic [7:0] lastMask, input int nRst,
                          input string name);
        logic [16:0] a;
        logic [31:0] d;
        int n;
        a = 17'($urandom);
        rc = fws_flash_model_i.resetCount;
        fws_flash_model_i.mode = m;
        fws_flash_model_i.left = lft;
        fws_flash_model_i.progData = dat;
        fws_flash_model_i.arrayByte = (m == 3'd2) ? 8'hff : dat;
        axi_wr(REG_ADDR, {15'h0, a});
        axi_wr(REG_DATA, {24'h0, dat});
        axi_wr(REG_CTRL, ctrl);
        if (lft > 8) axi_wr(REG_ADDR, {15'h0, ~a});
        for (n = 0; n < 400; n++) begin
            axi_rd(REG_STAT, 32'h0, 32'h0, d);
            if (!d[STAT_BUSY_POS] && (d[STAT_DONE_POS] || d[STAT_FAIL_POS] || !ctrl[0])) break;
        end
        if (n == 400) chk_word("busy cleared", 32'h0, 32'h1);
        axi_rd(REG_STAT, {28'h0, stMask}, {28'h0, st}, d);
        axi_rd(REG_DATA, {16'h0, lastMask, 8'hff}, {16'h0, last, dat}, d);
        axi_rd(REG_ADDR, 32'h1ffff, {15'h0, a}, d);
        if (ctrl[0] && !ctrl[2]) chk_word("poll address", {15'h0, a}, {15'h0, fws_flash_model_i.readAddr});
        chk_word("reset writes", 32'(nRst), 32'(fws_flash_model_i.resetCount - rc));
        $display("test %s finished, mismatches so far %0d", name, bad_count);
    endtask
    // =============================================================
    // Main sequence
    initial begin
        logic [31:0] d;
        seedDummy = $urandom(32'h37bd);
        repeat (20) @(posedge ref_clk);
        rst <= 1'b0;
        repeat (3) @(posedge ref_clk);
        axi_rd(REG_ADDR, 32'h1ffff, {15'h0, ADDR_RESET}, d);
        axi_rd(REG_DATA, 32'hff, {24'h0, DATA_RESET}, d);
        axi_rd(REG_STAT, 32'hf, 32'h0, d);
        $display("test register reset values finished");
        for (i = 0; i < 2; i++) begin
            pd = {i[0], 7'($urandom)};
            run_op(3'd1, 10 + int'($urandom % 11), pd, 32'h9, 4'h2, 4'hf, 8'h0, 8'h0, 0, "poll program");
        end
        run_op(3'd1, 1, 8'h3c, 32'h9, 4'h2, 4'hf, 8'h0, 8'h0, 0, "protected program");
        run_op(3'd2, 12, 8'h80, 32'h9, 4'h2, 4'hf, 8'h0, 8'h0, 0, "poll erase");
        pd = 8'($urandom) & 8'hdf;
        run_op(3'd1, 5, pd, 32'h1, 4'h2, 4'hf, pd, 8'hff, 0, "toggle program");
        run_op(3'd2, 4, 8'h80, 32'h1, 4'h2, 4'hf, 8'hff, 8'hff, 0, "toggle erase");
        run_op(3'd3, 0, 8'h80, 32'h1, 4'ha, 4'hf, 8'h0, 8'h0, 0, "toggle suspended");
        run_op(3'd4, 0, 8'h15, 32'h1, 4'h4, 4'h5, 8'h0, 8'h0, 1, "toggle failure");
        run_op(3'd4, 0, 8'h95, 32'h9, 4'h4, 4'h5, 8'h0, 8'h0, 1, "poll failure");
        run_op(3'd0, 0, 8'h00, 32'h5, 4'h2, 4'h7, 8'h0, 8'h0, 1, "reset command");
        wrap_up();
    end
    // Watchdog against hangs
    initial begin
        repeat (60000) @(posedge ref_clk);
        bad_count++;
        $display("[FAIL] run length expected finish seen hang");
        wrap_up();
    end
endmodule
`default_nettype wire
